// File: rtl/osc_switch_doze_ctrl.sv
`timescale 1ns/100ps
module osc_switch_doze_ctrl
	import osc_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [2:0] config_source_sel,
	input wire logic failsafe_option_cfg,
	input wire logic fail_detect,
	input wire logic source_stable,
	input wire logic pll_locked_in,
	input wire logic irq_event,
	input wire logic rc_tick,
	input wire logic xtal_tick,
	output logic [2:0] current_source_sel,
	output logic [2:0] target_source_sel,
	output logic osc_fail_trap,
	output logic pin_config_freeze,
	output logic peripheral_tick,
	output logic rc_div_tick,
	output logic [4:0] pll_input_prescaler,
	output logic [1:0] pll_output_divider,
	output logic [8:0] pll_feedback_multiplier,
	output logic [4:0] aux_multiplier,
	output logic pwm_fine_resolution,
	output logic ref_clk_out
);
	function automatic logic [7:0] div_mask(input logic [2:0] code, input logic long);
		div_mask = (long && code == 3'h7) ? 8'hFF : 8'((9'h001 << code) - 9'h001);
	endfunction

	function automatic logic uses_pll(input logic [2:0] code);
		uses_pll = (code == SRC_RC_PLL) || (code == SRC_PRI_PLL);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic aw_held, w_held, init_done;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [1:0] unlock_stage;
	logic [2:0] next_source_sel;
	logic clock_config_freeze, clock_fail_flag, switch_request, pll_lock_status;
	sw_state_t sw_state;
	logic recover_on_irq, cpu_ratio_enable;
	logic [2:0] doze_ratio, rc_postscaler;
	logic aux_loop_sel, ref_on, ref_sel;
	logic [3:0] ref_div;
	logic [7:0] doze_cnt, rc_cnt;
	logic [14:0] ref_cnt;

	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire ar_take = arvalid & arready;
	wire do_write = aw_held & w_held & ~bvalid;
	wire wr_osc = do_write & (wr_addr == OSC_CTRL_ADDR);
	wire wr_div = do_write & (wr_addr == CLK_DIV_ADDR);
	wire wr_fbd = do_write & (wr_addr == FBD_ADDR);
	wire wr_key = do_write & (wr_addr == KEY_ADDR);
	wire wr_aux = do_write & (wr_addr == AUX_ADDR);
	wire wr_hit = wr_osc | wr_div | wr_fbd | wr_key | wr_aux;
	wire unlocked = unlock_stage == 2'h2;
	wire osc_wr = wr_osc & unlocked;
	wire frozen = clock_config_freeze & failsafe_option_cfg;

	wire [15:0] osc_rd = {1'b0, current_source_sel, 1'b0, next_source_sel,
		clock_config_freeze, pin_config_freeze, pll_lock_status, 1'b0,
		clock_fail_flag, 2'h0, switch_request};
	wire [15:0] div_rd = {recover_on_irq, doze_ratio, cpu_ratio_enable, rc_postscaler,
		pll_output_divider, 1'b0, pll_input_prescaler};
	wire [15:0] aux_rd = {ref_on, 2'h0, ref_sel, ref_div, 7'h00, aux_loop_sel};
	wire [15:0] osc_wd = merge(osc_rd, wr_data, wr_strb);
	wire [15:0] div_wd = merge(div_rd, wr_data, wr_strb);
	wire [15:0] fbd_wd = merge({7'h00, pll_feedback_multiplier}, wr_data, wr_strb);
	wire [15:0] aux_wd = merge(aux_rd, wr_data, wr_strb);
	wire [2:0] wd_next_src = osc_wd[NEXT_SRC_LSB +: 3];
	wire [2:0] wd_doze = div_wd[DOZE_LSB +: 3];
	wire [1:0] wd_post = div_wd[POST_LSB +: 2];
	wire [2:0] doze_after = cpu_ratio_enable ? doze_ratio : wd_doze;
	wire rd_hit = (araddr == OSC_CTRL_ADDR) | (araddr == CLK_DIV_ADDR) |
		(araddr == FBD_ADDR) | (araddr == KEY_ADDR) | (araddr == AUX_ADDR);
	wire [15:0] rd_word = (araddr == OSC_CTRL_ADDR) ? osc_rd :
		(araddr == CLK_DIV_ADDR) ? div_rd :
		(araddr == FBD_ADDR) ? {7'h00, pll_feedback_multiplier} :
		(araddr == AUX_ADDR) ? aux_rd : 16'h0000;
	wire [7:0] doze_mask = div_mask(doze_ratio, 1'b0);
	wire [7:0] rc_mask = div_mask(rc_postscaler, 1'b1);
	wire [14:0] ref_half = 15'((16'h0001 << ref_div) >> 1);
	wire ref_step = ref_sel ? xtal_tick : 1'b1;
	wire ref_wrap = (ref_div == 4'h0) | ((ref_cnt & (ref_half - 15'h0001)) ==
		(ref_half - 15'h0001));

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Bus slave: address and data taken in either order, one response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			awready <= do_write | (~aw_held & ~aw_take);
			wready <= do_write | (~w_held & ~w_take);
			if (aw_take) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid & bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			arready <= (rvalid & rready) | (~rvalid & ~ar_take);
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata <= {16'h0000, rd_word};
				rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid & rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Unlock: two keys in turn, then one control write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unlock_stage <= 2'h0;
		end else if (wr_key) begin
			if (wr_data[7:0] == KEY_FIRST) begin
				unlock_stage <= 2'h1;
			end else if (unlock_stage == 2'h1 && wr_data[7:0] == KEY_SECOND) begin
				unlock_stage <= 2'h2;
			end else begin
				unlock_stage <= 2'h0;
			end
		end else if (do_write) begin
			unlock_stage <= 2'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_done <= 1'b0;
			next_source_sel <= SRC_RC;
			current_source_sel <= SRC_RC;
			target_source_sel <= SRC_RC;
			clock_config_freeze <= 1'b0;
			pin_config_freeze <= 1'b0;
			clock_fail_flag <= 1'b0;
			osc_fail_trap <= 1'b0;
			switch_request <= 1'b0;
			pll_lock_status <= 1'b0;
			sw_state <= SW_IDLE;
		end else begin
			if (!init_done) begin
				init_done <= 1'b1;
				next_source_sel <= config_source_sel;
				current_source_sel <= config_source_sel;
				target_source_sel <= config_source_sel;
			end
			pll_lock_status <= uses_pll(current_source_sel) & pll_locked_in;
			osc_fail_trap <= fail_detect | (osc_wr & osc_wd[FAIL_BIT]);
			if (osc_wr) begin
				clock_fail_flag <= osc_wd[FAIL_BIT];
				pin_config_freeze <= osc_wd[PINF_BIT];
			end
			if (fail_detect) begin
				clock_fail_flag <= 1'b1;
			end
			case (sw_state)
				SW_IDLE: begin
					if (switch_request && next_source_sel == SRC_RESERVED) begin
						switch_request <= 1'b0;
					end else if (switch_request) begin
						target_source_sel <= next_source_sel;
						sw_state <= SW_WAIT;
					end
				end
				SW_WAIT: begin
					if (source_stable && uses_pll(target_source_sel)) begin
						sw_state <= SW_LOCK;
					end else if (source_stable) begin
						current_source_sel <= target_source_sel;
						switch_request <= 1'b0;
						sw_state <= SW_IDLE;
					end
				end
				SW_LOCK: begin
					if (pll_locked_in) begin
						current_source_sel <= target_source_sel;
						switch_request <= 1'b0;
						sw_state <= SW_IDLE;
					end
				end
				default: sw_state <= SW_IDLE;
			endcase
			if (osc_wr && !frozen) begin
				next_source_sel <= wd_next_src;
				clock_config_freeze <= osc_wd[FREEZE_BIT];
				if (osc_wd[SWREQ_BIT]) begin
					switch_request <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			recover_on_irq <= 1'b0;
			doze_ratio <= DOZE_RST;
			cpu_ratio_enable <= 1'b0;
			rc_postscaler <= RCPS_RST;
			pll_output_divider <= POST_RST;
			pll_input_prescaler <= PRE_RST;
			pll_feedback_multiplier <= FBD_RST;
			aux_loop_sel <= 1'b0;
			ref_on <= 1'b0;
			ref_sel <= 1'b0;
			ref_div <= 4'h0;
			aux_multiplier <= AUX_MULT;
			pwm_fine_resolution <= 1'b0;
		end else begin
			aux_multiplier <= AUX_MULT;
			pwm_fine_resolution <= aux_loop_sel;
			if (wr_div) begin
				recover_on_irq <= div_wd[RECOVER_BIT];
				rc_postscaler <= div_wd[RCPS_LSB +: 3];
				if (!cpu_ratio_enable) begin
					doze_ratio <= wd_doze;
				end
				if (!div_wd[RATIO_EN_BIT]) begin
					cpu_ratio_enable <= 1'b0;
				end else if (doze_after != 3'h0) begin
					cpu_ratio_enable <= 1'b1;
				end
				if (!frozen) begin
					pll_input_prescaler <= div_wd[PRE_LSB +: 5];
					if (wd_post != POST_RESERVED) begin
						pll_output_divider <= wd_post;
					end
				end
			end
			if (irq_event && recover_on_irq) begin
				cpu_ratio_enable <= 1'b0;
			end
			if (wr_fbd && !frozen) begin
				pll_feedback_multiplier <= fbd_wd[8:0];
			end
			if (wr_aux) begin
				aux_loop_sel <= aux_wd[AUX_LOOP_BIT];
				ref_on <= aux_wd[REF_ON_BIT];
				if (!ref_on) begin
					ref_sel <= aux_wd[REF_SEL_BIT];
					ref_div <= aux_wd[REF_DIV_LSB +: 4];
				end
			end
		end
	end

	// Dividers: doze peripheral rate, RC postscaler, reference output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			doze_cnt <= 8'h00;
			rc_cnt <= 8'h00;
			ref_cnt <= 15'h0000;
			peripheral_tick <= 1'b0;
			rc_div_tick <= 1'b0;
			ref_clk_out <= 1'b0;
		end else begin
			doze_cnt <= doze_cnt + 8'h01;
			peripheral_tick <= ~cpu_ratio_enable | ((doze_cnt & doze_mask) == doze_mask);
			if (rc_tick) begin
				rc_cnt <= rc_cnt + 8'h01;
			end
			rc_div_tick <= rc_tick & ((rc_cnt & rc_mask) == rc_mask);
			if (!ref_on) begin
				ref_cnt <= 15'h0000;
				ref_clk_out <= 1'b0;
			end else if (ref_step) begin
				ref_cnt <= ref_cnt + 15'h0001;
				if (ref_wrap) begin
					ref_clk_out <= ~ref_clk_out;
				end
			end
		end
	end

	a_doze_hold: assert property (wr_div && cpu_ratio_enable |=> $stable(doze_ratio))
		else $error("doze field changed while enabled");
	a_doze_zero: assert property ($rose(cpu_ratio_enable) |-> doze_ratio != 3'h0)
		else $error("ratio enabled with zero doze");
	a_irq_recover: assert property (irq_event && recover_on_irq |=> !cpu_ratio_enable)
		else $error("interrupt did not recover ratio");
	a_ratio_one: assert property (!cpu_ratio_enable [*2] |-> peripheral_tick)
		else $error("peripheral tick missing at 1:1");
	a_reserved_tgt: assert property (sw_state == SW_IDLE && switch_request &&
		next_source_sel == SRC_RESERVED |=> !switch_request && $stable(current_source_sel))
		else $error("reserved code started a switch");
	a_fail_trap: assert property (fail_detect |=> clock_fail_flag && osc_fail_trap)
		else $error("failure not flagged");
	a_key_guard: assert property (wr_osc && !unlocked |=> $stable(next_source_sel))
		else $error("control write taken while locked");
	a_freeze_guard: assert property (frozen && (wr_fbd || wr_div) |=>
		$stable(pll_feedback_multiplier) && $stable(pll_input_prescaler))
		else $error("PLL settings changed while frozen");
	a_switch_wait: assert property ($past(init_done) && $changed(current_source_sel) |->
		$past(source_stable) || $past(pll_locked_in))
		else $error("source changed before stable");
	a_post_reserved: assert property (wr_div && wd_post == POST_RESERVED |=>
		$stable(pll_output_divider))
		else $error("reserved divider code accepted");
endmodule // osc_switch_doze_ctrl

// File: rtl/osc_ctrl_pkg.sv
package osc_ctrl_pkg;
	// Register byte offsets
	localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] CLK_DIV_ADDR = 8'h04;
	localparam logic [7:0] FBD_ADDR = 8'h08;
	localparam logic [7:0] KEY_ADDR = 8'h0C;
	localparam logic [7:0] AUX_ADDR = 8'h10;
	// Oscillator control fields
	localparam int CUR_SRC_LSB = 12;
	localparam int NEXT_SRC_LSB = 8;
	localparam int FREEZE_BIT = 7;
	localparam int PINF_BIT = 6;
	localparam int LOCK_BIT = 5;
	localparam int FAIL_BIT = 3;
	localparam int SWREQ_BIT = 0;
	// Clock divisor fields
	localparam int RECOVER_BIT = 15;
	localparam int DOZE_LSB = 12;
	localparam int RATIO_EN_BIT = 11;
	localparam int RCPS_LSB = 8;
	localparam int POST_LSB = 6;
	localparam int PRE_LSB = 0;
	// Auxiliary and reference fields
	localparam int REF_ON_BIT = 15;
	localparam int REF_SEL_BIT = 12;
	localparam int REF_DIV_LSB = 8;
	localparam int AUX_LOOP_BIT = 0;
	// Reset values and reserved divider code
	localparam logic [2:0] DOZE_RST = 3'h3;
	localparam logic [2:0] RCPS_RST = 3'h0;
	localparam logic [1:0] POST_RST = 2'h1;
	localparam logic [1:0] POST_RESERVED = 2'h2;
	localparam logic [4:0] PRE_RST = 5'h00;
	localparam logic [8:0] FBD_RST = 9'h030;
	localparam logic [4:0] AUX_MULT = 5'h10;
	// Unlock keys, values are arbitrary
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'h5A;
	// Source codes and bus response codes
	localparam logic [2:0] SRC_RC = 3'h0;
	localparam logic [2:0] SRC_RC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI = 3'h2;
	localparam logic [2:0] SRC_PRI_PLL = 3'h3;
	localparam logic [2:0] SRC_RESERVED = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		SW_IDLE = 3'b001,
		SW_WAIT = 3'b010,
		SW_LOCK = 3'b100
	} sw_state_t;
endpackage

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench
	import osc_ctrl_pkg::*;
;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, last_bresp;
	logic [31:0] rdata, rd_val;
	logic [1:0] rd_resp;
	logic [2:0] config_source_sel = SRC_PRI;
	logic failsafe_option_cfg = 0, fail_detect = 0, source_stable = 0, pll_locked_in = 0;
	logic irq_event = 0, rc_tick = 0, xtal_tick = 0;
	logic [2:0] current_source_sel, target_source_sel;
	logic osc_fail_trap, pin_config_freeze, peripheral_tick, rc_div_tick;
	logic [4:0] pll_input_prescaler, aux_multiplier;
	logic [1:0] pll_output_divider;
	logic [8:0] pll_feedback_multiplier;
	logic pwm_fine_resolution, ref_clk_out;
	int err_count = 0, num_checks = 0, traps = 0, pticks = 0, rticks = 0, rfticks = 0, t0;
	logic ref_prev = 1'b0;

	osc_switch_doze_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .config_source_sel(config_source_sel),
		.failsafe_option_cfg(failsafe_option_cfg), .fail_detect(fail_detect),
		.source_stable(source_stable), .pll_locked_in(pll_locked_in), .irq_event(irq_event),
		.rc_tick(rc_tick), .xtal_tick(xtal_tick), .current_source_sel(current_source_sel),
		.target_source_sel(target_source_sel), .osc_fail_trap(osc_fail_trap),
		.pin_config_freeze(pin_config_freeze), .peripheral_tick(peripheral_tick),
		.rc_div_tick(rc_div_tick), .pll_input_prescaler(pll_input_prescaler),
		.pll_output_divider(pll_output_divider),
		.pll_feedback_multiplier(pll_feedback_multiplier), .aux_multiplier(aux_multiplier),
		.pwm_fine_resolution(pwm_fine_resolution), .ref_clk_out(ref_clk_out));

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	// Event counters sampled at the same edges the bench uses
	always @(posedge aclk) begin
		if (osc_fail_trap === 1'b1) traps <= traps + 1;
		if (peripheral_tick === 1'b1) pticks <= pticks + 1;
		if (rc_div_tick === 1'b1) rticks <= rticks + 1;
		if (ref_clk_out === 1'b1 && ref_prev === 1'b0) rfticks <= rfticks + 1;
		ref_prev <= ref_clk_out;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task bump(inout int n);
		n++;
		if (n > 200) begin
			err_count++;
			$display("BAD %0t handshake timeout", $time);
			report_and_stop;
		end
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw, w;
		n = 0;
		aw = 1;
		w = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 0;
			end
			bump(n);
		end
		while (bvalid !== 1'b1) begin
			@(posedge aclk);
			bump(n);
		end
		last_bresp = bresp;
		bready <= 0;
	endtask

	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			bump(n);
		end while (arready !== 1'b1);
		arvalid <= 0;
		do begin
			@(posedge aclk);
			bump(n);
		end while (rvalid !== 1'b1);
		rd_val = rdata;
		rd_resp = rresp;
		rready <= 0;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_val, e);
		chk(32'(rd_resp), 32'(RESP_OKAY));
	endtask

	task unl;
		wr(KEY_ADDR, 32'(KEY_FIRST));
		wr(KEY_ADDR, 32'(KEY_SECOND));
	endtask

	task pulse_in(input int which);
		@(posedge aclk);
		if (which == 0) fail_detect <= 1;
		else irq_event <= 1;
		@(posedge aclk);
		fail_detect <= 0;
		irq_event <= 0;
	endtask

	initial begin
		wt(2);
		aresetn <= 1;
		rdchk(OSC_CTRL_ADDR, 32'h0000_2200);
		rdchk(CLK_DIV_ADDR, 32'h0000_3040);
		rdchk(FBD_ADDR, 32'h0000_0030);
		chk(32'(aux_multiplier), 32'h10);
		rd(8'h14);
		chk(32'(rd_resp), 32'(RESP_SLVERR));
		chk(rd_val, 32'h0);
		$display("test reset values done");
		wr(OSC_CTRL_ADDR, 32'h0040);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2200);
		unl;
		wr(CLK_DIV_ADDR, 32'h3040);
		wr(OSC_CTRL_ADDR, 32'h0040);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2200);
		unl;
		wr(OSC_CTRL_ADDR, 32'h0240);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2240);
		chk(32'(pin_config_freeze), 32'h1);
		$display("test unlock done");
		unl;
		wr(OSC_CTRL_ADDR, 32'h0141);
		wt(10);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2141);
		chk(32'(target_source_sel), 32'(SRC_RC_PLL));
		source_stable <= 1;
		wt(10);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2141);
		pll_locked_in <= 1;
		wt(5);
		rdchk(OSC_CTRL_ADDR, 32'h0000_1160);
		chk(32'(current_source_sel), 32'(SRC_RC_PLL));
		unl;
		wr(OSC_CTRL_ADDR, 32'h0441);
		wt(5);
		rdchk(OSC_CTRL_ADDR, 32'h0000_1460);
		chk(32'(current_source_sel), 32'(SRC_RC_PLL));
		$display("test switch done");
		t0 = traps;
		pulse_in(0);
		wt(2);
		rdchk(OSC_CTRL_ADDR, 32'h0000_1468);
		unl;
		wr(OSC_CTRL_ADDR, 32'h0440);
		rdchk(OSC_CTRL_ADDR, 32'h0000_1460);
		unl;
		wr(OSC_CTRL_ADDR, 32'h0448);
		wt(2);
		rdchk(OSC_CTRL_ADDR, 32'h0000_1468);
		chk(32'(traps - t0), 32'd2);
		$display("test clock fail done");
		wr(CLK_DIV_ADDR, 32'h0840);
		rdchk(CLK_DIV_ADDR, 32'h0000_0040);
		wr(CLK_DIV_ADDR, 32'h2040);
		wr(CLK_DIV_ADDR, 32'h2840);
		rdchk(CLK_DIV_ADDR, 32'h0000_2840);
		@(posedge aclk);
		t0 = pticks;
		wt(16);
		chk(32'(pticks - t0), 32'd4);
		wr(CLK_DIV_ADDR, 32'h5840);
		rdchk(CLK_DIV_ADDR, 32'h0000_2840);
		pulse_in(1);
		rdchk(CLK_DIV_ADDR, 32'h0000_2840);
		wr(CLK_DIV_ADDR, 32'hA840);
		pulse_in(1);
		rdchk(CLK_DIV_ADDR, 32'h0000_A040);
		@(posedge aclk);
		t0 = pticks;
		wt(16);
		chk(32'(pticks - t0), 32'd16);
		$display("test doze done");
		wr(CLK_DIV_ADDR, 32'hA7DF);
		chk(32'(pll_output_divider), 32'h3);
		chk(32'(pll_input_prescaler), 32'h1F);
		wr(CLK_DIV_ADDR, 32'hA79F);
		rdchk(CLK_DIV_ADDR, 32'h0000_A7DF);
		@(posedge aclk);
		rc_tick <= 1;
		wt(4);
		t0 = rticks;
		wt(512);
		chk(32'(rticks - t0), 32'd2);
		rc_tick <= 0;
		wr(FBD_ADDR, 32'h01FF);
		chk(32'(pll_feedback_multiplier), 32'h1FF);
		wr(AUX_ADDR, 32'h8201);
		t0 = rfticks;
		wt(16);
		chk(32'(rfticks - t0), 32'd4);
		chk(32'(pwm_fine_resolution), 32'h1);
		wr(AUX_ADDR, 32'h0001);
		wr(AUX_ADDR, 32'h9101);
		t0 = rfticks;
		wt(16);
		chk(32'(rfticks - t0), 32'd0);
		xtal_tick <= 1'b1;
		wt(2);
		t0 = rfticks;
		wt(16);
		chk(32'(rfticks - t0), 32'd8);
		xtal_tick <= 1'b0;
		wr(8'h14, 32'h1234);
		chk(32'(last_bresp), 32'(RESP_SLVERR));
		$display("test divider fields done");
		failsafe_option_cfg <= 1;
		unl;
		wr(OSC_CTRL_ADDR, 32'h0080);
		rdchk(OSC_CTRL_ADDR, 32'h0000_10A0);
		wr(CLK_DIV_ADDR, 32'hA7C0);
		chk(32'(pll_input_prescaler), 32'h1F);
		wr(FBD_ADDR, 32'h0030);
		chk(32'(pll_feedback_multiplier), 32'h1FF);
		$display("test freeze done");
		@(posedge aclk);
		aresetn <= 0;
		wt(2);
		aresetn <= 1;
		rdchk(CLK_DIV_ADDR, 32'h0000_3040);
		rdchk(OSC_CTRL_ADDR, 32'h0000_2200);
		$display("test second reset done");
		report_and_stop;
	end
endmodule // testbench
